// *** include/fault_routing_pkg.sv ***
package fault_routing_pkg;
    // Sizes
    localparam int ENGINES    = 4;
    localparam int MODULES    = 4;
    localparam int SLOTS      = ENGINES * MODULES;
    localparam int DIG        = 4;
    localparam int ANA        = 7;
    localparam int EXT        = 4;
    localparam int ENG_EV     = 5;
    localparam int GLOBAL_EV  = 18;
    localparam int EVENTS     = GLOBAL_EV + ENG_EV;
    localparam int COUNT_W    = 8;
    localparam int DATA_W     = 12;
    localparam int ANA_TH_W   = 8;
    // Event bit positions in a mask word
    localparam int EV_DIG     = 0;
    localparam int EV_ANA     = 4;
    localparam int EV_EXT     = 11;
    localparam int EV_HF      = 15;
    localparam int EV_LF      = 16;
    localparam int EV_DCM     = 17;
    localparam int EV_ENG     = 18;
    // Module slots inside an engine
    localparam int MOD_CYCLE_LIMIT = 0;
    localparam int MOD_AB          = 1;
    localparam int MOD_A           = 2;
    localparam int MOD_B           = 3;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] EXT_OFF    = 8'h04;
    localparam logic [7:0] MISC_OFF   = 8'h08;
    localparam logic [7:0] FLAGS_OFF  = 8'h0C;
    localparam logic [7:0] EVENT_OFF  = 8'h10;
    localparam logic [7:0] DIG_OFF    = 8'h20;
    localparam logic [7:0] ANA_OFF    = 8'h40;
    localparam logic [7:0] MASK_OFF   = 8'h80;
    localparam logic [7:0] LIMIT_OFF  = 8'hC0;
    // Field positions
    localparam int CTRL_EN_LSB    = 0;
    localparam int CTRL_FEN_LSB   = 4;
    localparam int CTRL_MATCH_LSB = 8;
    localparam int EXT_POL_LSB    = 4;
    localparam int MISC_HF_BIT    = 0;
    localparam int MISC_LF_BIT    = 1;
    localparam int MISC_DCM_BIT   = 2;
    localparam int ANA_EN_BIT     = 8;
    // Reset values
    localparam logic [11:0] CTRL_RESET  = 12'h000;
    localparam logic [7:0]  EXT_RESET   = 8'h00;
    localparam logic [2:0]  MISC_RESET  = 3'h0;
    localparam logic [7:0]  LIMIT_RESET = 8'h00;
    // Timing
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int HF_TIMEOUT_PS  = 100000;
    localparam int LF_TIMEOUT_PS  = 4000000;
    localparam int HF_TIMEOUT_CYC = (HF_TIMEOUT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LF_TIMEOUT_CYC = (LF_TIMEOUT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OSC_CNT_W      = 11;
    localparam int FAULT_IRQ_PRIORITY = 25;
    // Per-engine carriers
    typedef struct packed {
        logic              cycleStart;
        logic              pcmTrip;
        logic [ENG_EV-1:0] engineFault;
    } engine_in_type;
    typedef struct packed {
        logic               forceOffA;
        logic               forceOffB;
        logic               cutA;
        logic               cutB;
        logic [MODULES-1:0] faultFlag;
    } engine_out_type;
endpackage : fault_routing_pkg

// *** rtl/fault_routing.sv ***
// Function
// - four identical fault modules per engine
// - one fault counted per switching cycle
// - flag when run count exceeds limit
// - flag holds until engine enable drops
// - engine enable clears all four flags
// - one fault enable gates all modules
// - several sources may combine per input
// - one source may feed many engines
// - firmware mask selects each input's sources
// - one cycle-limit block per engine
// - four digital comparators with thresholds
// - seven analog comparator configurations
// - external pins become fault events
// - five engine-generated fault events
// - oscillator failure detection as events
// - discontinuous conduction detection event
// - fault interrupt request at level 25
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fault_routing
    import fault_routing_pkg::*;
(
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    // AHB-Lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    // Comparator front ends
    input  wire logic [DIG-1:0][DATA_W-1:0]   digValue,
    input  wire logic [ANA-1:0]               anaTrip,
    output logic [ANA-1:0][ANA_TH_W-1:0]      anaThreshold,
    input  wire logic [EXT-1:0]               extPin,
    input  wire logic                         hfClkTick,
    input  wire logic                         lfClkTick,
    input  wire logic                         dcmZeroCross,
    input  wire logic                         ovDetect,
    input  wire logic                         uvDetect,
    input  wire logic                         loadStep,
    output logic                              faultIrqReq,
    // Engines
    input  wire engine_in_type [ENGINES-1:0]  engineIn,
    output engine_out_type [ENGINES-1:0]      engineOut,
    output logic [ENGINES-1:0]                pwmEngineEnable
);
    logic [11:0]          ctrl_reg;
    logic [7:0]           ext_reg;
    logic [2:0]           misc_reg;
    logic [DATA_W-1:0]    dig_reg [DIG];
    logic [8:0]           ana_reg [ANA];
    logic [EVENTS-1:0]    mask_reg [SLOTS];
    logic [COUNT_W-1:0]   limit_reg [SLOTS];
    logic [COUNT_W-1:0]   count_reg [SLOTS];
    logic [SLOTS-1:0]     hit_reg;
    logic [SLOTS-1:0]     flag_reg;
    logic [GLOBAL_EV-1:0] event_reg;
    logic [ENG_EV-1:0]    engEv_reg [ENGINES];
    logic [ENGINES-1:0]   cutA_reg;
    logic [1:0]           tickPrev_reg;
    logic [1:0]           oscFail_reg;
    logic [OSC_CNT_W-1:0] oscCnt_reg [2];
    logic                 dcmSeen_reg;
    logic                 dcmEvent_reg;
    logic                 wrPend_reg;
    logic                 rdValid;
    logic [7:0]           wrAddr_reg;
    logic [31:0]          rdata_reg;
    logic [31:0]          readValue;
    logic [ENGINES-1:0]   engEn;
    logic [ENGINES-1:0]   faultEn;
    logic [SLOTS-1:0]     faultIn;
    logic [SLOTS-1:0]     seen;
    logic [1:0]           tick;

    assign engEn   = ctrl_reg[CTRL_EN_LSB +: ENGINES];
    assign faultEn = ctrl_reg[CTRL_FEN_LSB +: ENGINES];
    assign tick    = {lfClkTick, hfClkTick};

    // Bus answers at once, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;
    assign rdValid   = hsel & htrans[1] & ~hwrite & hready & (haddr[31:8] == 24'h0);

    // Address phase capture
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
        end else if (hready) begin
            wrPend_reg <= hsel & htrans[1] & hwrite & (haddr[31:8] == 24'h0);
            wrAddr_reg <= haddr[7:0];
        end
    end

    // Read decode; unmapped reads as zero
    always_comb begin
        readValue = 32'h0000_0000;
        if (haddr[7:0] == CTRL_OFF) begin
            readValue[11:0] = ctrl_reg;
        end else if (haddr[7:0] == EXT_OFF) begin
            readValue[7:0] = ext_reg;
        end else if (haddr[7:0] == MISC_OFF) begin
            readValue[2:0] = misc_reg;
        end else if (haddr[7:0] == FLAGS_OFF) begin
            readValue[SLOTS-1:0] = flag_reg;
        end else if (haddr[7:0] == EVENT_OFF) begin
            readValue[GLOBAL_EV-1:0] = event_reg;
        end else if (haddr[7:4] == DIG_OFF[7:4]) begin
            readValue[DATA_W-1:0] = dig_reg[haddr[3:2]];
        end else if (haddr[7:5] == ANA_OFF[7:5] && haddr[4:2] != 3'h7) begin
            readValue[8:0] = ana_reg[haddr[4:2]];
        end else if (haddr[7:6] == MASK_OFF[7:6]) begin
            readValue[EVENTS-1:0] = mask_reg[haddr[5:2]];
        end else if (haddr[7:4] == LIMIT_OFF[7:4]) begin
            for (int m = 0; m < MODULES; m++) begin
                readValue[8*m +: 8] = limit_reg[{haddr[3:2], 2'(m)}];
            end
        end
    end

    // Read data captured in the address phase
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rdValid) begin
            rdata_reg <= readValue;
        end
    end

    // Configuration writes in the data phase
    // firmware source select
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl_reg <= CTRL_RESET;
            ext_reg  <= EXT_RESET;
            misc_reg <= MISC_RESET;
            for (int i = 0; i < DIG; i++) dig_reg[i] <= '1;
            for (int i = 0; i < ANA; i++) ana_reg[i] <= 9'h000;
            for (int i = 0; i < SLOTS; i++) begin
                mask_reg[i]  <= '0;
                limit_reg[i] <= LIMIT_RESET;
            end
        end else if (wrPend_reg) begin
            if (wrAddr_reg == CTRL_OFF) begin
                ctrl_reg <= hwdata[11:0];
            end else if (wrAddr_reg == EXT_OFF) begin
                ext_reg <= hwdata[7:0];
            end else if (wrAddr_reg == MISC_OFF) begin
                misc_reg <= hwdata[2:0];
            end else if (wrAddr_reg[7:4] == DIG_OFF[7:4]) begin
                dig_reg[wrAddr_reg[3:2]] <= hwdata[DATA_W-1:0];
            end else if (wrAddr_reg[7:5] == ANA_OFF[7:5] && wrAddr_reg[4:2] != 3'h7) begin
                ana_reg[wrAddr_reg[4:2]] <= hwdata[8:0];
            end else if (wrAddr_reg[7:6] == MASK_OFF[7:6]) begin
                mask_reg[wrAddr_reg[5:2]] <= hwdata[EVENTS-1:0];
            end else if (wrAddr_reg[7:4] == LIMIT_OFF[7:4]) begin
                for (int m = 0; m < MODULES; m++) begin
                    limit_reg[{wrAddr_reg[3:2], 2'(m)}] <= hwdata[8*m +: 8];
                end
            end
        end
    end

    // Analog thresholds out, engine enables out
    // analog comparator config
    always_comb begin
        for (int i = 0; i < ANA; i++) anaThreshold[i] = ana_reg[i][ANA_TH_W-1:0];
    end
    assign pwmEngineEnable = engEn;

    // Global fault event register
    // digital compare, pins
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            event_reg <= '0;
        end else begin
            for (int i = 0; i < DIG; i++) begin
                event_reg[EV_DIG+i] <= digValue[i] > dig_reg[i];
            end
            for (int i = 0; i < ANA; i++) begin
                event_reg[EV_ANA+i] <= anaTrip[i] & ana_reg[i][ANA_EN_BIT];
            end
            for (int i = 0; i < EXT; i++) begin
                event_reg[EV_EXT+i] <= ext_reg[i] & (extPin[i] == ext_reg[EXT_POL_LSB+i]);
            end
            event_reg[EV_HF]  <= oscFail_reg[0] & misc_reg[MISC_HF_BIT];
            event_reg[EV_LF]  <= oscFail_reg[1] & misc_reg[MISC_LF_BIT];
            event_reg[EV_DCM] <= dcmEvent_reg & misc_reg[MISC_DCM_BIT];
        end
    end

    // Oscillator watchdogs, one per oscillator
    // clock failure detect
    for (genvar k = 0; k < 2; k++) begin : g_osc
        localparam logic [OSC_CNT_W-1:0] LIMIT =
            OSC_CNT_W'(k == 0 ? HF_TIMEOUT_CYC : LF_TIMEOUT_CYC);
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                tickPrev_reg[k] <= 1'b0;
                oscCnt_reg[k]   <= '0;
                oscFail_reg[k]  <= 1'b0;
            end else begin
                tickPrev_reg[k] <= tick[k];
                if (tick[k] != tickPrev_reg[k]) begin
                    oscCnt_reg[k]  <= '0;
                    oscFail_reg[k] <= 1'b0;
                end else if (oscCnt_reg[k] == LIMIT) begin
                    oscFail_reg[k] <= 1'b1;
                end else begin
                    oscCnt_reg[k] <= oscCnt_reg[k] + 1'b1;
                end
            end
        end
        a_osc_recover: assert property (@(posedge ref_clk) disable iff (!reset_n)
            tick[k] != tickPrev_reg[k] |=> !oscFail_reg[k])
            else $error("oscillator fail stuck after tick");
    end

    // Zero crossing seen during engine 0 cycle
    // discontinuous conduction
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            dcmSeen_reg  <= 1'b0;
            dcmEvent_reg <= 1'b0;
        end else if (engineIn[0].cycleStart) begin
            dcmEvent_reg <= dcmSeen_reg | dcmZeroCross;
            dcmSeen_reg  <= 1'b0;
        end else if (dcmZeroCross) begin
            dcmSeen_reg <= 1'b1;
        end
    end

    // Shared fault interrupt request
    // fault interrupt
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            faultIrqReq <= 1'b0;
        end else begin
            faultIrqReq <= (|event_reg[EV_ANA +: ANA]) | ovDetect | uvDetect | loadStep;
        end
    end
    a_irq_raise: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ovDetect || uvDetect || loadStep |=> faultIrqReq)
        else $error("fault interrupt not raised");

    // Per-engine logic
    for (genvar e = 0; e < ENGINES; e++) begin : g_eng
        // Engine fault events sampled
        // engine fault events
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                engEv_reg[e] <= '0;
            end else begin
                engEv_reg[e] <= engineIn[e].engineFault;
            end
        end

        // Peak current cut, trip wins over cycle restart
        // cycle-limit block
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                cutA_reg[e] <= 1'b0;
            end else if (!engEn[e]) begin
                cutA_reg[e] <= 1'b0;
            end else if (engineIn[e].pcmTrip && faultEn[e]) begin
                cutA_reg[e] <= 1'b1;
            end else if (engineIn[e].cycleStart) begin
                cutA_reg[e] <= 1'b0;
            end
        end

        // Output forcing, registered
        // force inactive
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                engineOut[e] <= '0;
            end else begin
                engineOut[e].forceOffA <= faultEn[e] & (flag_reg[4*e+MOD_CYCLE_LIMIT]
                    | flag_reg[4*e+MOD_AB] | flag_reg[4*e+MOD_A]);
                engineOut[e].forceOffB <= faultEn[e] & (flag_reg[4*e+MOD_CYCLE_LIMIT]
                    | flag_reg[4*e+MOD_AB] | flag_reg[4*e+MOD_B]);
                engineOut[e].cutA      <= cutA_reg[e];
                engineOut[e].cutB      <= cutA_reg[e] & ctrl_reg[CTRL_MATCH_LSB+e];
                engineOut[e].faultFlag <= flag_reg[4*e +: MODULES];
            end
        end
        a_force_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
            faultEn[e] && flag_reg[4*e+MOD_A] |=> engineOut[e].forceOffA)
            else $error("flag did not force output off");
        a_shared_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
            !faultEn[e] |=> !engineOut[e].forceOffA && !engineOut[e].forceOffB)
            else $error("output forced with fault enable low");
        a_cut_trip: assert property (@(posedge ref_clk) disable iff (!reset_n)
            engEn[e] && faultEn[e] && engineIn[e].pcmTrip |=> ##1 engineOut[e].cutA)
            else $error("peak current trip did not cut output");

        // Four identical fault modules
        // identical modules
        for (genvar m = 0; m < MODULES; m++) begin : g_mod
            localparam int S = 4 * e + m;
            logic [COUNT_W:0] countNext;

            // Source mux: any masked event, cut for the cycle-limit slot
            // shared enable, combined, shared
            assign faultIn[S] = faultEn[e] & ((|(mask_reg[S] & {engEv_reg[e], event_reg}))
                | (m == MOD_CYCLE_LIMIT && cutA_reg[e]));
            assign seen[S]    = hit_reg[S] | faultIn[S];
            assign countNext  = {1'b0, count_reg[S]} + 9'h001;

            // At most one hit per cycle
            // once per cycle
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    hit_reg[S] <= 1'b0;
                end else if (!engEn[e] || engineIn[e].cycleStart) begin
                    hit_reg[S] <= 1'b0;
                end else if (faultIn[S]) begin
                    hit_reg[S] <= 1'b1;
                end
            end

            // Run count, saturating
            // run reset
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    count_reg[S] <= '0;
                end else if (!engEn[e]) begin
                    count_reg[S] <= '0;
                end else if (engineIn[e].cycleStart) begin
                    if (!seen[S]) begin
                        count_reg[S] <= '0;
                    end else if (!countNext[COUNT_W]) begin
                        count_reg[S] <= countNext[COUNT_W-1:0];
                    end
                end
            end

            // Sticky flag, cleared only by engine disable
            // limit compare, sticky, shared clear
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    flag_reg[S] <= 1'b0;
                end else if (!engEn[e]) begin
                    flag_reg[S] <= 1'b0;
                end else if (engineIn[e].cycleStart && seen[S]
                             && countNext > {1'b0, limit_reg[S]}) begin
                    flag_reg[S] <= 1'b1;
                end
            end

            sequence faultyEnd;
                engEn[e] && engineIn[e].cycleStart && seen[S];
            endsequence
            sequence cleanEnd;
                engEn[e] && engineIn[e].cycleStart && !seen[S];
            endsequence
            a_flag_limit: assert property (@(posedge ref_clk) disable iff (!reset_n)
                $rose(flag_reg[S]) |-> count_reg[S] > limit_reg[S])
                else $error("flag set at or below limit");
            a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
                flag_reg[S] && engEn[e] |=> flag_reg[S])
                else $error("flag dropped while enabled");
            a_disable_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
                !engEn[e] |=> !flag_reg[S] && count_reg[S] == 8'h00)
                else $error("engine disable did not clear module");
            a_count_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
                engEn[e] && !engineIn[e].cycleStart |=> $stable(count_reg[S]))
                else $error("count moved inside a cycle");
            a_run_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
                cleanEnd |=> count_reg[S] == 8'h00)
                else $error("clean cycle kept run count");
            a_run_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
                faultyEnd ##0 count_reg[S] != 8'hFF
                    |=> count_reg[S] == $past(count_reg[S]) + 8'h01)
                else $error("faulty cycle not counted once");
        end
    end
endmodule : fault_routing
`default_nettype wire

// *** tb/engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module engine_model
    import fault_routing_pkg::*;
#(
    parameter int PERIOD = 8
)(
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           reset_n,
    // Levels from the bench
    input  wire logic [ENGINES-1:0]             pcmTrip,
    input  wire logic [ENGINES-1:0][ENG_EV-1:0] engFault,
    // Engine side of the block
    output engine_in_type [ENGINES-1:0]         engineIn
);
    int cnt;
    // Switching period counter, engines in step
    always_ff @(posedge ref_clk) begin
        if (!reset_n || cnt == PERIOD - 1) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // One pulse per period, levels passed through
    always_comb begin
        for (int e = 0; e < ENGINES; e++) begin
            engineIn[e].cycleStart  = reset_n && cnt == PERIOD - 1;
            engineIn[e].pcmTrip     = pcmTrip[e];
            engineIn[e].engineFault = engFault[e];
        end
    end
endmodule : engine_model
`default_nettype wire

// *** tb/tb_fault_routing.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_fault_routing;
    import fault_routing_pkg::*;
    typedef struct {
        logic [31:0] mask;
        logic [6:0]  ana;
        logic [3:0]  ext;
        logic [11:0] dig;
        logic [4:0]  ef;
        logic        exp;
    } row_type;
    logic                           ref_clk, reset_n, hsel, hwrite, hreadyout, hresp, faultIrqReq;
    logic [1:0]                     htrans;
    logic [2:0]                     irqSrc;
    logic                           dcmZc, hfTick;
    logic [31:0]                    haddr, hwdata, hrdata, rd;
    logic [DIG-1:0][DATA_W-1:0]     digValue;
    logic [ANA-1:0]                 anaTrip;
    logic [ANA-1:0][ANA_TH_W-1:0]   anaThreshold;
    logic [EXT-1:0]                 extPin;
    logic [ENGINES-1:0]             pcmTrip, pwmEngineEnable;
    logic [ENGINES-1:0][ENG_EV-1:0] engFault;
    engine_in_type [ENGINES-1:0]    engineIn;
    engine_out_type [ENGINES-1:0]   engineOut;
    int                             n_mismatch = 0, n_checks = 0, cyc = 0;
    row_type                        rows [6] = '{
        '{32'h10, 7'h01, 4'h0, 12'h000, 5'h00, 1'b1}, '{32'h10, 7'h02, 4'h0, 12'h000, 5'h00, 1'b0},
        '{32'h801, 7'h00, 4'h1, 12'h000, 5'h00, 1'b1}, '{32'h801, 7'h00, 4'h0, 12'h200, 5'h00, 1'b1},
        '{32'h40000, 7'h00, 4'h0, 12'h000, 5'h01, 1'b1}, '{32'h0, 7'h7F, 4'hF, 12'hFFF, 5'h1F, 1'b0}};
    fault_routing dut (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .digValue(digValue),
        .anaTrip(anaTrip), .anaThreshold(anaThreshold), .extPin(extPin), .hfClkTick(hfTick),
        .lfClkTick(1'b0), .dcmZeroCross(dcmZc), .ovDetect(irqSrc[0]), .uvDetect(irqSrc[1]),
        .loadStep(irqSrc[2]), .faultIrqReq(faultIrqReq), .engineIn(engineIn),
        .engineOut(engineOut), .pwmEngineEnable(pwmEngineEnable));
    engine_model partner (.ref_clk(ref_clk), .reset_n(reset_n), .pcmTrip(pcmTrip),
        .engFault(engFault), .engineIn(engineIn));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // Word compare, four-state
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Single output bit compare
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1
    // One AHB-Lite single transfer, waits on hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // Faulty switching cycles, two trip pulses in each
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            do @(negedge ref_clk); while (!engineIn[0].cycleStart);
            repeat (2) begin
                @(posedge ref_clk) anaTrip <= 7'h01;
                @(posedge ref_clk) anaTrip <= 7'h00;
            end
        end
        repeat (12) @(posedge ref_clk);
    endtask : pulses
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        {reset_n, hsel, hwrite, htrans, haddr, hwdata, irqSrc} = '0;
        {digValue, anaTrip, extPin, pcmTrip, engFault, dcmZc, hfTick} = '0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        bus(0, CTRL_OFF, 0);
        chk(rd, 32'h0);
        chk1(hresp, 1'b0);
        bus(0, DIG_OFF, 0);
        chk(rd, 32'h0000_0FFF);
        bus(0, 8'hF0, 0);
        chk(rd, 32'h0);
        $display("test reset done");
        bus(1, EXT_OFF, 32'h11);
        bus(1, ANA_OFF, 32'h15A);
        bus(1, ANA_OFF + 8'h04, 32'h100);
        bus(1, DIG_OFF, 32'h100);
        bus(1, CTRL_OFF, 32'h011);
        chk({24'h0, anaThreshold[0]}, 32'h5A);
        foreach (rows[i]) begin
            bus(1, MASK_OFF, rows[i].mask);
            @(posedge ref_clk);
            {anaTrip, extPin, digValue[0], engFault[0]} <= {rows[i].ana, rows[i].ext, rows[i].dig, rows[i].ef};
            repeat (24) @(posedge ref_clk);
            {anaTrip, extPin, digValue[0], engFault[0]} <= '0;
            repeat (4) @(posedge ref_clk);
            bus(0, FLAGS_OFF, 0);
            chk(rd, {31'h0, rows[i].exp});
            chk1(engineOut[0].forceOffA, rows[i].exp);
            bus(1, CTRL_OFF, 0);
            bus(0, FLAGS_OFF, 0);
            chk(rd, 32'h0);
            bus(1, CTRL_OFF, 32'h011);
        end
        $display("test routing rows done");
        bus(1, MASK_OFF, 32'h10);
        bus(1, LIMIT_OFF, 32'h2);
        pulses(2);
        pulses(0);
        repeat (8) @(posedge ref_clk);
        pulses(2);
        bus(0, FLAGS_OFF, 0);
        chk(rd, 32'h0);
        pulses(3);
        bus(0, FLAGS_OFF, 0);
        chk(rd, 32'h1);
        $display("test run count done");
        bus(1, LIMIT_OFF, 32'h0);
        bus(1, CTRL_OFF, 0);
        bus(1, CTRL_OFF, 32'h001);
        pulses(2);
        bus(0, FLAGS_OFF, 0);
        chk(rd, 32'h0);
        bus(1, CTRL_OFF, 32'h0FF);
        for (int e = 1; e < ENGINES; e++) begin
            bus(1, MASK_OFF + 8'(16 * e), 32'h10);
        end
        pulses(1);
        bus(0, FLAGS_OFF, 0);
        chk(rd, 32'h1111);
        chk1(engineOut[3].forceOffB, 1'b1);
        chk({28'h0, engineOut[3].faultFlag}, 32'h1);
        chk({28'h0, pwmEngineEnable}, 32'hF);
        $display("test fan out done");
        bus(1, CTRL_OFF, 32'h1FF);
        @(posedge ref_clk) pcmTrip <= 4'h1;
        repeat (3) @(posedge ref_clk);
        chk1(engineOut[0].cutA, 1'b1);
        chk1(engineOut[0].cutB, 1'b1);
        pcmTrip <= 4'h0;
        for (int i = 0; i < 3; i++) begin
            irqSrc <= 3'(1 << i);
            repeat (3) @(posedge ref_clk);
            chk1(faultIrqReq, 1'b1);
            irqSrc <= 3'h0;
            repeat (3) @(posedge ref_clk);
            chk1(faultIrqReq, 1'b0);
        end
        $display("test cut and request done");
        bus(1, MISC_OFF, 32'h7);
        dcmZc <= 1'b1;
        repeat (1000) @(posedge ref_clk);
        bus(0, EVENT_OFF, 0);
        chk(rd, 32'h0003_8000);
        hfTick <= 1'b1;
        repeat (2) @(posedge ref_clk);
        bus(0, EVENT_OFF, 0);
        chk(rd, 32'h0003_0000);
        $display("test clock and conduction done");
        report_and_stop();
    end
endmodule : tb_fault_routing
`default_nettype wire
